// *** include/rcc_pkg.sv ***
package rcc_pkg;
    // Channel map of one card
    localparam int NUM_CH = 25;
    localparam int NUM_MEAS = 22;
    localparam int NUM_SIG = 20;
    localparam int HALF_SIG = 10;
    localparam logic [4:0] CH_FIRST = 5'h01;
    localparam logic [4:0] CH_CUR_A = 5'h15;
    localparam logic [4:0] CH_CUR_B = 5'h16;
    localparam logic [4:0] CH_SIG_LAST = 5'h14;
    localparam logic [4:0] CH_PRI_LAST = 5'h0A;
    localparam logic [4:0] CH_PAIR_OFS = 5'h0A;
    localparam int IDX_POLE = 22;
    localparam int IDX_SENSE_BP = 23;
    localparam int IDX_INPUT_BP = 24;
    // Slot digits and count store
    localparam logic [2:0] SLOT_MIN = 3'h1;
    localparam logic [2:0] SLOT_MAX = 3'h5;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 5;
    // Update interval in minutes
    localparam logic [10:0] INTERVAL_MIN = 11'h00A;
    localparam logic [10:0] INTERVAL_MAX = 11'h5A0;
    localparam logic [10:0] INTERVAL_FACTORY = 11'h00F;
    // One minute at 10 MHz
    localparam int CLK_HZ = 10000000;
    localparam int MINUTE_S = 60;
    localparam int MINUTE_CYCLES = CLK_HZ * MINUTE_S;
    // Measurement functions
    typedef enum logic [3:0] {
        FN_DC_VOLTS = 4'h0,
        FN_AC_VOLTS = 4'h1,
        FN_DC_CURRENT = 4'h2,
        FN_AC_CURRENT = 4'h3,
        FN_OHMS_2W = 4'h4,
        FN_OHMS_4W = 4'h5,
        FN_CONTINUITY = 4'h6,
        FN_FREQUENCY = 4'h7,
        FN_PERIOD = 4'h8,
        FN_TEMP_2W = 4'h9,
        FN_TEMP_RTD_4W = 4'hA,
        FN_RATIO = 4'hB,
        FN_CHAN_AVERAGE = 4'hC
    } rcc_func_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_LOAD = 3'h0,
        ST_IDLE = 3'h1,
        ST_FLUSH = 3'h2,
        ST_QUERY = 3'h3,
        ST_QWAIT = 3'h4
    } rcc_state_t;
endpackage

// *** design/rcc_count_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcc_count_ram
    import rcc_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [CNT_W-1:0] wr_data_i,
    // Read port
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [CNT_W-1:0] rd_data_o
);
    logic [CNT_W-1:0] mem [0:NUM_CH-1];

    // Plain RAM, no reset, so contents come from the nonvolatile load
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// *** design/rcc_relay_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcc_relay_ctrl
    import rcc_pkg::*;
#(
    parameter int MINUTE_CYC = MINUTE_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Function and channel commands
    input wire logic [3:0] func_i,
    input wire logic close_i,
    input wire logic open_all_i,
    input wire logic [4:0] close_ch_i,
    input wire logic multi_i,
    input wire logic multi_bp_set_i,
    input wire logic multi_sense_bp_i,
    input wire logic multi_input_bp_i,
    input wire logic preset_i,
    // Interval programming
    input wire logic int_wr_i,
    input wire logic [10:0] int_val_i,
    // Count query over a span
    input wire logic query_i,
    input wire logic [4:0] query_first_i,
    input wire logic [4:0] query_last_i,
    // Nonvolatile store port
    input wire logic nv_ready_i,
    input wire logic [CNT_W-1:0] nv_rd_data_i,
    output logic nv_rd_o,
    output logic nv_wr_o,
    output logic [ADDR_W-1:0] nv_addr_o,
    output logic [CNT_W-1:0] nv_wr_data_o,
    // Status and answers
    output logic [NUM_CH-1:0] relay_o,
    output logic [10:0] interval_o,
    output logic cnt_valid_o,
    output logic [4:0] cnt_ch_o,
    output logic [CNT_W-1:0] cnt_data_o,
    output logic query_done_o,
    output logic busy_o
);
    // Four-wire classification
    function automatic logic is_four_wire(input logic [3:0] f);
        is_four_wire = (f == FN_OHMS_4W) || (f == FN_TEMP_RTD_4W) ||
            (f == FN_RATIO) || (f == FN_CHAN_AVERAGE);
    endfunction

    function automatic logic is_current(input logic [3:0] f);
        is_current = (f == FN_DC_CURRENT) || (f == FN_AC_CURRENT);
    endfunction

    rcc_state_t state_reg;
    logic [NUM_CH-1:0] relay_reg;
    logic [NUM_CH-1:0] relay_next;
    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] pend_reg;
    logic [ADDR_W-1:0] idx_reg;
    logic [ADDR_W-1:0] qend_reg;
    logic [10:0] interval_reg;
    logic [31:0] cyc_reg;
    logic [10:0] min_reg;
    logic tick_due_reg;
    logic q_pend_reg;
    logic [4:0] q_first_reg;
    logic [4:0] q_last_reg;
    logic ram_we;
    logic [ADDR_W-1:0] ram_waddr;
    logic [CNT_W-1:0] ram_wdata;
    logic [ADDR_W-1:0] ram_raddr;
    logic [CNT_W-1:0] ram_rdata;
    logic [1:0] phase_reg;
    logic four_w;
    logic cur_f;
    logic ch_ok;

    assign four_w = is_four_wire(func_i);
    assign cur_f = is_current(func_i);

    // Channel legal for the selected function
    always_comb begin
        if (cur_f) begin
            ch_ok = (close_ch_i == CH_CUR_A) || (close_ch_i == CH_CUR_B);
        end else if (four_w) begin
            ch_ok = (close_ch_i >= CH_FIRST) && (close_ch_i <= CH_PRI_LAST);
        end else begin
            ch_ok = (close_ch_i >= CH_FIRST) && (close_ch_i <= CH_SIG_LAST);
        end
    end

    // Next relay image; index is channel minus one
    always_comb begin
        relay_next = relay_reg;
        if (state_reg == ST_LOAD) begin
            relay_next = '0;
        end else begin
            if (open_all_i) begin
                relay_next[NUM_MEAS-1:0] = '0;
            end else if (close_i && ch_ok) begin
                relay_next[NUM_MEAS-1:0] = '0;
                relay_next[close_ch_i - CH_FIRST] = 1'b1;
                if (four_w) begin
                    relay_next[close_ch_i - CH_FIRST + CH_PAIR_OFS] = 1'b1;
                end
            end
            // Function decides pole relay, and backplane relays unless in multi mode
            relay_next[IDX_POLE] = four_w;
            if (multi_i) begin
                if (multi_bp_set_i) begin
                    relay_next[IDX_SENSE_BP] = multi_sense_bp_i;
                    relay_next[IDX_INPUT_BP] = multi_input_bp_i;
                end
            end else begin
                // Current path skips isolation relays
                relay_next[IDX_SENSE_BP] = four_w;
                relay_next[IDX_INPUT_BP] = !cur_f;
            end
        end
    end

    assign rise = relay_next & ~relay_reg;

    // Relay image
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_reg <= '0;
        end else begin
            relay_reg <= relay_next;
        end
    end

    // Closures waiting to be counted; set beats clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~((state_reg == ST_IDLE && phase_reg == 2'h2) ?
                (NUM_CH'(1) << idx_reg) : '0)) | rise;
        end
    end

    // Interval; preset does not touch it, only reset restores factory
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            interval_reg <= INTERVAL_FACTORY;
        end else if (int_wr_i && int_val_i >= INTERVAL_MIN && int_val_i <= INTERVAL_MAX) begin
            interval_reg <= int_val_i;
        end
    end

    // Minute timer; restarts after each flush
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_reg <= '0;
            min_reg <= '0;
            tick_due_reg <= 1'b0;
        end else if (state_reg == ST_FLUSH) begin
            cyc_reg <= '0;
            min_reg <= '0;
            tick_due_reg <= 1'b0;
        end else if (cyc_reg == 32'(MINUTE_CYC - 1)) begin
            cyc_reg <= '0;
            if (min_reg + 11'h001 >= interval_reg) begin
                tick_due_reg <= 1'b1;
                min_reg <= '0;
            end else begin
                min_reg <= min_reg + 11'h001;
            end
        end else begin
            cyc_reg <= cyc_reg + 32'h00000001;
        end
    end

    // Query latch; held until the last word of the answer goes out
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_pend_reg <= 1'b0;
            q_first_reg <= '0;
            q_last_reg <= '0;
        end else if (query_i && !q_pend_reg) begin
            q_pend_reg <= 1'b1;
            q_first_reg <= query_first_i;
            q_last_reg <= query_last_i;
        end else if (state_reg == ST_QWAIT && idx_reg == qend_reg && phase_reg == 2'h2) begin
            q_pend_reg <= 1'b0;
        end
    end

    // Sequencer: load, count, flush, answer
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_LOAD;
            idx_reg <= '0;
            qend_reg <= '0;
            phase_reg <= 2'h0;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    // Reading store before any counting
                    if (phase_reg == 2'h0 && nv_ready_i) begin
                        phase_reg <= 2'h1;
                    end else if (phase_reg == 2'h1) begin
                        phase_reg <= 2'h2; // Store answers a cycle after the strobe
                    end else if (phase_reg == 2'h2) begin
                        phase_reg <= 2'h0;
                        if (idx_reg == ADDR_W'(NUM_CH - 1)) begin
                            idx_reg <= '0;
                            state_reg <= ST_IDLE;
                        end else begin
                            idx_reg <= idx_reg + 5'h01;
                        end
                    end
                end
                ST_IDLE: begin
                    // Scan pending bits one by one: read, then write plus one
                    if (phase_reg == 2'h0) begin
                        if (pend_reg[idx_reg]) begin
                            phase_reg <= 2'h1;
                        end else if ((tick_due_reg || q_pend_reg) && pend_reg == '0) begin
                            // Flush only once every closure is in the working copy
                            idx_reg <= '0;
                            state_reg <= ST_FLUSH;
                        end else begin
                            idx_reg <= (idx_reg == ADDR_W'(NUM_CH - 1)) ? '0 : idx_reg + 5'h01;
                        end
                    end else if (phase_reg == 2'h1) begin
                        phase_reg <= 2'h2;
                    end else begin
                        phase_reg <= 2'h0;
                    end
                end
                ST_FLUSH: begin
                    if (phase_reg == 2'h0 && nv_ready_i) begin
                        phase_reg <= 2'h1;
                    end else if (phase_reg == 2'h1) begin
                        phase_reg <= 2'h2;
                    end else if (phase_reg == 2'h2) begin
                        phase_reg <= 2'h0;
                        if (idx_reg == ADDR_W'(NUM_CH - 1)) begin
                            state_reg <= q_pend_reg ? ST_QUERY : ST_IDLE;
                            idx_reg <= '0;
                        end else begin
                            idx_reg <= idx_reg + 5'h01;
                        end
                    end
                end
                ST_QUERY: begin
                    idx_reg <= ADDR_W'(q_first_reg - CH_FIRST);
                    qend_reg <= ADDR_W'(q_last_reg - CH_FIRST);
                    state_reg <= ST_QWAIT;
                end
                ST_QWAIT: begin
                    if (phase_reg == 2'h2) begin
                        phase_reg <= 2'h0;
                        if (idx_reg == qend_reg) begin
                            idx_reg <= '0;
                            state_reg <= ST_IDLE;
                        end else begin
                            idx_reg <= idx_reg + 5'h01;
                        end
                    end else begin
                        phase_reg <= phase_reg + 2'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    phase_reg <= 2'h0;
                end
            endcase
        end
    end

    // Working-count RAM ports
    assign ram_raddr = idx_reg;
    assign ram_waddr = idx_reg;
    assign ram_we = (state_reg == ST_LOAD && phase_reg == 2'h2) ||
        (state_reg == ST_IDLE && phase_reg == 2'h2);
    assign ram_wdata = (state_reg == ST_LOAD) ? nv_rd_data_i : ram_rdata + 32'h00000001;

    rcc_count_ram u_ram (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(ram_we),
        .wr_addr_i(ram_waddr),
        .wr_data_i(ram_wdata),
        .rd_addr_i(ram_raddr),
        .rd_data_o(ram_rdata)
    );

    // Store port and answer outputs, all registered
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_rd_o <= 1'b0;
            nv_wr_o <= 1'b0;
            nv_addr_o <= '0;
            nv_wr_data_o <= '0;
            cnt_valid_o <= 1'b0;
            cnt_ch_o <= '0;
            cnt_data_o <= '0;
            query_done_o <= 1'b0;
        end else begin
            nv_rd_o <= state_reg == ST_LOAD && phase_reg == 2'h0 && nv_ready_i;
            nv_wr_o <= state_reg == ST_FLUSH && phase_reg == 2'h2;
            nv_addr_o <= idx_reg;
            nv_wr_data_o <= ram_rdata;
            cnt_valid_o <= state_reg == ST_QWAIT && phase_reg == 2'h2;
            cnt_ch_o <= 5'(idx_reg + CH_FIRST);
            cnt_data_o <= ram_rdata;
            query_done_o <= state_reg == ST_QWAIT && phase_reg == 2'h2 && idx_reg == qend_reg;
        end
    end

    // Mirrors of state
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_o <= '0;
            interval_o <= INTERVAL_FACTORY;
            busy_o <= 1'b1;
        end else begin
            relay_o <= relay_next;
            interval_o <= interval_reg;
            busy_o <= state_reg != ST_IDLE;
        end
    end

    // Checks
    sequence flush_go_s;
        state_reg == ST_FLUSH && phase_reg == 2'h2;
    endsequence
    sequence flush_wr_s;
        nv_wr_o;
    endsequence

    // Function terms spelled out in pole_fn_a and input_bp_a; the other checks use the decode above
    count_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(pend_reg[0]) |-> $past(rise[0])) else $error("pending set without edge");
    one_meas_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !four_w |-> $countones(relay_next[NUM_MEAS-1:0]) <= 1) else $error("two channels closed");
    pole_fn_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg != ST_LOAD |=> relay_o[IDX_POLE] ==
        ($past(func_i) inside {FN_OHMS_4W, FN_TEMP_RTD_4W, FN_RATIO, FN_CHAN_AVERAGE}))
        else $error("pole relay wrong");
    pair_close_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        close_i && ch_ok && four_w && !open_all_i && state_reg != ST_LOAD |=>
        relay_o[$past(close_ch_i) - CH_FIRST + CH_PAIR_OFS]) else $error("sense pair open");
    current_only_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cur_f && close_i |-> ch_ok == (close_ch_i >= CH_CUR_A && close_ch_i <= CH_CUR_B))
        else $error("current channel gate");
    input_bp_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !multi_i && state_reg != ST_LOAD |=> relay_o[IDX_INPUT_BP] ==
        !($past(func_i) inside {FN_DC_CURRENT, FN_AC_CURRENT})) else $error("input bp");
    interval_rng_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        interval_reg >= INTERVAL_MIN && interval_reg <= INTERVAL_MAX) else $error("interval out");
    flush_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        flush_go_s |=> flush_wr_s) else $error("flush write missing");
    load_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == ST_LOAD |-> !ram_we || phase_reg == 2'h2) else $error("count during load");
    preset_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        preset_i && !int_wr_i |=> $stable(interval_reg)) else $error("preset moved interval");
endmodule
`default_nettype wire

// *** tb/rcc_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcc_store_model
    import rcc_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Pacing
    input wire logic slow_i,
    // Store port
    input wire logic nv_rd_i,
    input wire logic nv_wr_i,
    input wire logic [ADDR_W-1:0] nv_addr_i,
    input wire logic [CNT_W-1:0] nv_wr_data_i,
    output logic nv_ready_o,
    output logic [CNT_W-1:0] nv_rd_data_o
);
    logic [CNT_W-1:0] mem [NUM_CH];
    logic ready_reg = 1'h1;
    // Nonzero preload, so a skipped load shows up in the counts
    initial begin
        for (int k = 0; k < NUM_CH; k++) begin
            mem[k] = 32'h0000_0100 + k;
        end
        nv_rd_data_o = 32'h0;
    end
    // Slow mode toggles ready to stretch every transfer
    always @(posedge ref_clk_i) begin
        ready_reg <= slow_i ? ~ready_reg : 1'h1;
        if (nv_wr_i) begin
            mem[nv_addr_i] <= nv_wr_data_i;
        end
        // Read data lasts one cycle, then scrambles
        nv_rd_data_o <= nv_rd_i ? mem[nv_addr_i] : ~nv_rd_data_o;
    end
    assign nv_ready_o = ready_reg;
endmodule
`default_nettype wire

// *** tb/test_relay_channel_count_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_relay_channel_count_control
    import rcc_pkg::*;
;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [3:0] func_i = FN_DC_CURRENT;
    logic close_i = 1'h0, open_all_i = 1'h0, multi_i = 1'h0, multi_bp_set_i = 1'h0;
    logic multi_sense_bp_i = 1'h0, multi_input_bp_i = 1'h0, preset_i = 1'h0;
    logic int_wr_i = 1'h0, query_i = 1'h0, slow = 1'h0;
    logic [4:0] close_ch_i = 5'h01, query_first_i = 5'h01, query_last_i = 5'h01;
    logic [10:0] int_val_i = 11'h00F;
    logic nv_ready_i, nv_rd_o, nv_wr_o, cnt_valid_o, query_done_o, busy_o;
    logic [CNT_W-1:0] nv_rd_data_i, nv_wr_data_o, cnt_data_o;
    logic [ADDR_W-1:0] nv_addr_o;
    logic [NUM_CH-1:0] relay_o;
    logic [10:0] interval_o;
    logic [4:0] cnt_ch_o;
    // Reference model state
    int cnt [NUM_CH];
    logic [24:0] exp_img;
    int exp_int;
    int bad_count = 0, n_compared = 0, seed = 4563;

    always #50 ref_clk_i = ~ref_clk_i;

    // Short minute keeps interval flushes within the run
    rcc_relay_ctrl #(.MINUTE_CYC(20)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .func_i(func_i),
        .close_i(close_i), .open_all_i(open_all_i), .close_ch_i(close_ch_i), .multi_i(multi_i),
        .multi_bp_set_i(multi_bp_set_i), .multi_sense_bp_i(multi_sense_bp_i),
        .multi_input_bp_i(multi_input_bp_i), .preset_i(preset_i), .int_wr_i(int_wr_i),
        .int_val_i(int_val_i), .query_i(query_i), .query_first_i(query_first_i),
        .query_last_i(query_last_i), .nv_ready_i(nv_ready_i), .nv_rd_data_i(nv_rd_data_i),
        .nv_rd_o(nv_rd_o), .nv_wr_o(nv_wr_o), .nv_addr_o(nv_addr_o), .nv_wr_data_o(nv_wr_data_o),
        .relay_o(relay_o), .interval_o(interval_o), .cnt_valid_o(cnt_valid_o), .cnt_ch_o(cnt_ch_o),
        .cnt_data_o(cnt_data_o), .query_done_o(query_done_o), .busy_o(busy_o));
    rcc_store_model store (.ref_clk_i(ref_clk_i), .slow_i(slow), .nv_rd_i(nv_rd_o), .nv_wr_i(nv_wr_o),
        .nv_addr_i(nv_addr_o), .nv_wr_data_i(nv_wr_data_o), .nv_ready_o(nv_ready_i),
        .nv_rd_data_o(nv_rd_data_i));

    function automatic bit is_four(logic [3:0] f);
        return f == FN_OHMS_4W || f == FN_TEMP_RTD_4W || f == FN_RATIO || f == FN_CHAN_AVERAGE;
    endfunction
    function automatic bit is_cur(logic [3:0] f);
        return f == FN_DC_CURRENT || f == FN_AC_CURRENT;
    endfunction
    // Pole and backplane image owed to a function
    function automatic logic [24:0] fbits(logic [3:0] f);
        logic [24:0] b;
        b = '0;
        b[IDX_POLE] = is_four(f);
        b[IDX_SENSE_BP] = is_four(f);
        b[IDX_INPUT_BP] = !is_cur(f);
        return b;
    endfunction

    task automatic report_and_stop();
        $display("Compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        $display("Error wait expected completion seen timeout");
        report_and_stop();
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic test_end(string s);
        $display("Test %s done", s);
    endtask
    task automatic check_relay(logic [24:0] e);
        n_compared++;
        if (relay_o !== e) begin
            bad_count++;
            $display("Error relay_o expected %h seen %h", e, relay_o);
        end
    endtask
    task automatic check_word(string name, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    // Every open-to-closed step in the model adds one closure
    task automatic set_img(logic [24:0] n);
        for (int k = 0; k < NUM_CH; k++) begin
            if (n[k] && !exp_img[k]) cnt[k]++;
        end
        exp_img = n;
    endtask
    // Long settle lets the design's count scan see each change
    task automatic settle_check();
        cyc(80);
        check_relay(exp_img);
    endtask
    task automatic close_ch(int ch);
        logic [24:0] n;
        n = exp_img;
        if (is_cur(func_i) ? (ch == 21 || ch == 22) : (ch >= 1 && ch <= (is_four(func_i) ? 10 : 20))) begin
            n = fbits(func_i);
            n[ch-1] = 1'h1;
            if (is_four(func_i) && ch <= 10) n[ch+9] = 1'h1;
        end
        close_ch_i = 5'(ch);
        close_i = 1'h1;
        cyc(1);
        close_i = 1'h0;
        set_img(n);
        settle_check();
    endtask
    task automatic open_all();
        open_all_i = 1'h1;
        cyc(1);
        open_all_i = 1'h0;
        set_img(exp_img & 25'h1C00000);
        settle_check();
    endtask
    task automatic set_func(logic [3:0] f);
        func_i = f;
        cyc(1);
        set_img(fbits(f));
        settle_check();
    endtask
    task automatic bp_set(logic s, logic i);
        logic [24:0] n;
        n = exp_img;
        n[IDX_SENSE_BP] = s;
        n[IDX_INPUT_BP] = i;
        multi_sense_bp_i = s;
        multi_input_bp_i = i;
        multi_bp_set_i = 1'h1;
        cyc(1);
        multi_bp_set_i = 1'h0;
        set_img(n);
        settle_check();
    endtask
    task automatic wr_int(int v);
        int_val_i = 11'(v);
        int_wr_i = 1'h1;
        cyc(1);
        int_wr_i = 1'h0;
        if (v >= 10 && v <= 1440) exp_int = v;
        cyc(2);
        check_word("interval_o", 32'(exp_int), 32'(interval_o));
    endtask
    // Words in channel order, done on the last, store flushed
    task automatic query(int first, int last);
        int k;
        k = first;
        query_first_i = 5'(first);
        query_last_i = 5'(last);
        query_i = 1'h1;
        cyc(1);
        query_i = 1'h0;
        for (int t = 0; t < 2000 && k <= last; t++) begin
            cyc(1);
            if (cnt_valid_o === 1'h1) begin
                check_word("cnt_ch_o", 32'(k), 32'(cnt_ch_o));
                check_word("cnt_data_o", cnt[k-1], cnt_data_o);
                check_word("query_done_o", 32'(k == last), 32'(query_done_o));
                k++;
            end
        end
        if (k <= last) timeout();
        for (int i = 0; i < NUM_CH; i++) check_word("stored count", cnt[i], store.mem[i]);
        cyc(4);
        test_end("query");
    endtask

    initial begin
        for (int k = 0; k < NUM_CH; k++) cnt[k] = 32'h100 + k;
        exp_img = '0;
        exp_int = 15;
        cyc(16);
        rst_i = 1'h0;
        for (int t = 0; t < 1000 && busy_o !== 1'h0; t++) cyc(1);
        if (busy_o !== 1'h0) timeout();
        check_word("interval_o", 32'h0F, 32'(interval_o));
        check_relay(exp_img);
        test_end("reset");
        // Every function code, one legal and one refused close each
        for (int f = 0; f < 13; f++) begin
            open_all();
            set_func(4'(f));
            close_ch(is_cur(4'(f)) ? 21 : 4);
            close_ch(is_cur(4'(f)) ? 4 : 22);
        end
        test_end("functions");
        open_all();
        set_func(FN_DC_VOLTS);
        close_ch(3);
        close_ch(3);
        close_ch(7);
        repeat (4) close_ch(1 + ($unsigned($random(seed)) % 20));
        slow = 1'h1;
        query(1, 25);
        slow = 1'h0;
        query(4, 4);
        query(11, 20);
        wr_int(9);
        wr_int(1441);
        wr_int(1440);
        wr_int(10 + ($unsigned($random(seed)) % 1431));
        preset_i = 1'h1;
        cyc(1);
        preset_i = 1'h0;
        cyc(2);
        check_word("interval_o", 32'(exp_int), 32'(interval_o));
        wr_int(10);
        test_end("interval");
        close_ch(1);
        close_ch(9);
        for (int t = 0; t < 600 && store.mem[8] !== 32'(cnt[8]); t++) cyc(1);
        check_word("timed flush", cnt[8], store.mem[8]);
        test_end("timed flush");
        multi_i = 1'h1;
        cyc(2);
        bp_set(1'h1, 1'h0);
        bp_set(1'h0, 1'h1);
        multi_i = 1'h0;
        test_end("multiple");
        report_and_stop();
    end
endmodule
`default_nettype wire
